// >>> design/cap2_config_regs.sv
// second-generation device/link/slot capability bank of one switch port
// assumes one config request per cycle, answered on the next edge
`include "cap2_regs.svh"
`default_nettype none
module cap2_config_regs
  import cap2_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // port role and external presets
  input wire logic isDownstream,
  input wire logic presetLoad,
  input wire preset_t preset,
  // config access
  input wire logic reqValid,
  input wire cfgReq_t req,
  output logic rdValid,
  output logic [31:0] rdData,
  // control to the port logic
  output var linkCtl_t linkCtl
);
  logic ariEn_q, ariEn_d;
  logic [12:0] lctl_q, lctl_d;
  logic deempInit_q, deempInit_d;
  logic [2:0] bar_q, bar_d;
  logic [7:0] nextPtr_q, nextPtr_d;
  logic [15:0] vendor_q, vendor_d;
  logic [15:0] device_q, device_d;
  logic rdValid_q, rdValid_d;
  logic [31:0] rdData_q, rdData_d;
  logic [31:0] readWord, merged;
  logic wrEn;

  // role is taken after reset release, not under the async reset
  typedef enum logic [1:0] {INIT = 2'b01, RUN = 2'b10} phase_t;
  phase_t phase_q, phase_d;

  function automatic logic [31:0] readMux(input logic [7:0] a,
    input logic dn, input logic ari, input logic [12:0] lc,
    input logic [2:0] b, input logic [7:0] np, input logic [15:0] vc,
    input logic [15:0] dc);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `OFF_DEVCAP2: r[`BIT_ARI] = dn;
      `OFF_DEVCTL2: r[`BIT_ARI] = ari;
      `OFF_LNKCTL2:
      begin
        r[12:0] = lc;
        r[`POS_CURDEEMP] = ~lc[`POS_DEEMP];
      end
      `OFF_SSCAP: r[15:0] = {np, `SSCAP_ID};
      `OFF_SSCODE: r = {dc, vc};
      `OFF_BARCFG: r[2:0] = dn ? 3'h0 : b;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign readWord = readMux(req.addr, isDownstream, ariEn_q, lctl_q, bar_q,
    nextPtr_q, vendor_q, device_q);
  assign wrEn = reqValid && req.wr && phase_q == RUN;

  cap2_wr_merge uMerge
  (
    .oldVal(readWord),
    .wdata(req.wdata),
    .be(req.be),
    .newVal(merged)
  );

  always_comb
  begin
    phase_d = phase_q;
    ariEn_d = ariEn_q;
    lctl_d = lctl_q;
    deempInit_d = deempInit_q;
    bar_d = bar_q;
    nextPtr_d = nextPtr_q;
    vendor_d = vendor_q;
    device_d = device_q;
    rdValid_d = reqValid && !req.wr;
    rdData_d = rdData_q;
    case (phase_q)
      INIT:
      begin
        phase_d = RUN;
        lctl_d[`POS_DEEMP] = isDownstream;
        deempInit_d = isDownstream;
      end
      RUN:
      begin
        if (wrEn)
        begin
          case (req.addr)
            `OFF_DEVCTL2: ariEn_d = merged[`BIT_ARI];
            `OFF_LNKCTL2: lctl_d = merged[12:0];
            `OFF_BARCFG: if (!isDownstream) bar_d = merged[2:0];
            default: ;
          endcase
        end
      end
      default: phase_d = INIT;
    endcase
    if (presetLoad)
    begin
      nextPtr_d = preset.nextPtr;
      vendor_d = preset.vendorCode;
      device_d = preset.deviceCode;
    end
    if (reqValid && !req.wr)
      rdData_d = readWord;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      phase_q <= INIT;
      ariEn_q <= 1'b0;
      lctl_q <= {9'h000, `RST_SPEED};
      deempInit_q <= 1'b0;
      bar_q <= {1'b0, `RST_BARTYPE};
      nextPtr_q <= `RST_NEXTPTR;
      vendor_q <= `RST_VENDOR;
      device_q <= `RST_DEVICE;
      rdValid_q <= 1'b0;
      rdData_q <= 32'h0000_0000;
    end
    else
    begin
      phase_q <= phase_d;
      ariEn_q <= ariEn_d;
      lctl_q <= lctl_d;
      deempInit_q <= deempInit_d;
      bar_q <= bar_d;
      nextPtr_q <= nextPtr_d;
      vendor_q <= vendor_d;
      device_q <= device_d;
      rdValid_q <= rdValid_d;
      rdData_q <= rdData_d;
    end
  end

  assign rdValid = rdValid_q;
  assign rdData = rdData_q;

  // control outputs; ARI, de-emphasis, upstream-only link bits and BAR ones gated by port role
  always_comb
  begin
    linkCtl.ariEnable = ariEn_q && isDownstream;
    linkCtl.targetSpeed = lctl_q[3:0];
    linkCtl.enterCompliance = lctl_q[`POS_COMPL];
    linkCtl.hwSpeedChangeDisable = lctl_q[`POS_HWSPD];
    linkCtl.deempSixDb = isDownstream ? ~lctl_q[`POS_DEEMP] : 1'b0;
    linkCtl.transmitMargin = lctl_q[9:7];
    linkCtl.modifiedCompliance = lctl_q[`POS_MODCOMPL] && !isDownstream;
    linkCtl.complianceSkipOrderedSets = lctl_q[`POS_SKIPOS] && !isDownstream;
    linkCtl.complianceDeemp = lctl_q[`POS_CDEEMP] && !isDownstream;
    linkCtl.barEnable = !isDownstream && bar_q[1:0] != `BARTYPE_OFF;
    linkCtl.bar64 = !isDownstream && bar_q[1:0] == `BARTYPE_64;
    linkCtl.barPrefetch = !isDownstream && bar_q[`POS_BARPF];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // reset values seen at the first edge after release, role-based de-emphasis defaults at the second
  AST_RESET_VAL: assert property (
    $rose(nrst) |-> !ariEn_q && lctl_q[3:0] == `RST_SPEED
    && bar_q == {1'b0, `RST_BARTYPE} && !rdValid)
    else $error("reset value wrong");

  AST_DEEMP_INIT: assert property (
    $rose(nrst) |=> lctl_q[`POS_DEEMP] == isDownstream
    && deempInit_q == isDownstream)
    else $error("de-emphasis default wrong");

  // read answers, one cycle after the request
  AST_ARI_CAP: assert property (
    reqValid && !req.wr && req.addr == `OFF_DEVCAP2
    |=> rdValid && rdData == {26'h0, $past(isDownstream), 5'h0})
    else $error("ari capability read wrong");

  AST_ARI_RD: assert property (
    reqValid && !req.wr && req.addr == `OFF_DEVCTL2
    |=> rdValid && rdData == {26'h0, $past(ariEn_q), 5'h0})
    else $error("ari enable read wrong");

  AST_CUR_DEEMP: assert property (
    reqValid && !req.wr && req.addr == `OFF_LNKCTL2
    |=> rdData[16] == ~rdData[6]
    && rdData[12:0] == $past(lctl_q))
    else $error("current de-emphasis polarity wrong");

  AST_LNK_RSVD: assert property (
    reqValid && !req.wr && req.addr == `OFF_LNKCTL2
    |=> rdData[31:17] == 15'h0 && rdData[15:13] == 3'h0)
    else $error("link control reserved bits not zero");

  AST_SSCAP: assert property (
    reqValid && !req.wr && req.addr == `OFF_SSCAP
    |=> rdData[7:0] == `SSCAP_ID && rdData[31:16] == 16'h0)
    else $error("capability id wrong");

  AST_NEXTPTR: assert property (
    reqValid && !req.wr && req.addr == `OFF_SSCAP
    |=> rdData[15:8] == $past(nextPtr_q))
    else $error("next-item pointer wrong");

  AST_CODES: assert property (
    reqValid && !req.wr && req.addr == `OFF_SSCODE
    |=> rdData == {$past(device_q), $past(vendor_q)})
    else $error("subsystem codes read wrong");

  AST_UNSUP: assert property (
    reqValid && !req.wr && (req.addr == `OFF_LNKCAP2
    || req.addr == `OFF_SLTCAP2 || req.addr == `OFF_SLTCTL2)
    |=> rdData == 32'h0)
    else $error("unsupported register not zero");

  AST_BAR_RD: assert property (
    reqValid && !req.wr && req.addr == `OFF_BARCFG
    |=> rdData[31:3] == 29'h0 && (!isDownstream || rdData[2:0] == 3'h0))
    else $error("bar configuration read wrong");

  // writes take effect on the next edge
  AST_ARI_EN: assert property (
    wrEn && req.addr == `OFF_DEVCTL2 && req.be[0]
    |=> linkCtl.ariEnable == ($past(req.wdata[5]) && isDownstream))
    else $error("ari enable not stored");

  AST_SPEED_WR: assert property (
    wrEn && req.addr == `OFF_LNKCTL2 && req.be[0]
    |=> linkCtl.targetSpeed == $past(req.wdata[3:0]))
    else $error("target speed not stored");

  AST_COMPL: assert property (
    wrEn && req.addr == `OFF_LNKCTL2 && req.be[0]
    |=> linkCtl.enterCompliance == $past(req.wdata[4]))
    else $error("compliance request not stored");

  AST_HWSPD: assert property (
    wrEn && req.addr == `OFF_LNKCTL2 && req.be[0]
    |=> linkCtl.hwSpeedChangeDisable == $past(req.wdata[5]))
    else $error("speed-change disable not stored");

  AST_MARGIN: assert property (
    wrEn && req.addr == `OFF_LNKCTL2 && req.be[1:0] == 2'h3
    |=> linkCtl.transmitMargin == $past(req.wdata[9:7]))
    else $error("transmit margin not stored");

  AST_DEEMP_WR: assert property (
    wrEn && req.addr == `OFF_LNKCTL2 && req.be[0]
    |=> linkCtl.deempSixDb == (isDownstream && !$past(req.wdata[6])))
    else $error("de-emphasis select not applied");

  AST_UP_ONLY: assert property (
    wrEn && req.addr == `OFF_LNKCTL2 && req.be[1]
    |=> linkCtl.modifiedCompliance
    == ($past(req.wdata[10]) && !isDownstream)
    && linkCtl.complianceSkipOrderedSets
    == ($past(req.wdata[11]) && !isDownstream)
    && linkCtl.complianceDeemp
    == ($past(req.wdata[12]) && !isDownstream))
    else $error("upstream-only bits wrong");

  AST_BAR_WR: assert property (
    wrEn && req.addr == `OFF_BARCFG && req.be[0] && !isDownstream
    |=> linkCtl.barEnable == ($past(req.wdata[1:0]) != `BARTYPE_OFF)
    && linkCtl.bar64 == ($past(req.wdata[1:0]) == `BARTYPE_64))
    else $error("bar type not applied");

  AST_BAR_PF: assert property (
    wrEn && req.addr == `OFF_BARCFG && req.be[0] && !isDownstream
    |=> linkCtl.barPrefetch == $past(req.wdata[`POS_BARPF]))
    else $error("bar prefetch not applied");

  // read-only state ignores writes but takes presets
  AST_BAR_DOWN: assert property (
    wrEn && req.addr == `OFF_BARCFG && isDownstream |=> $stable(bar_q))
    else $error("bar written on downstream port");

  AST_RO_KEEP: assert property (
    wrEn && !presetLoad
    && (req.addr == `OFF_SSCAP || req.addr == `OFF_SSCODE)
    |=> $stable(nextPtr_q) && $stable(vendor_q) && $stable(device_q))
    else $error("read-only code changed by write");

  AST_PRESET: assert property (
    presetLoad |=> nextPtr_q == $past(preset.nextPtr)
    && vendor_q == $past(preset.vendorCode)
    && device_q == $past(preset.deviceCode))
    else $error("preset not taken");

  COV_WRITE_LINK: cover property (wrEn && req.addr == `OFF_LNKCTL2);
  COV_BAR64: cover property (linkCtl.bar64);
  COV_ARI_COMPL: cover property (linkCtl.ariEnable
    && linkCtl.enterCompliance);
  COV_PRESET_READ: cover property (presetLoad ##[1:6] reqValid && !req.wr
    && req.addr == `OFF_SSCODE);
endmodule
`default_nettype wire

// >>> design/cap2_pkg.sv
// types for the capability register bank
// assumes nothing beyond the constants header
`default_nettype none
package cap2_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfgReq_t;
  typedef struct packed {
    logic [7:0] nextPtr;
    logic [15:0] vendorCode;
    logic [15:0] deviceCode;
  } preset_t;
  typedef struct packed {
    logic ariEnable;
    logic [3:0] targetSpeed;
    logic enterCompliance;
    logic hwSpeedChangeDisable;
    logic deempSixDb;
    logic [2:0] transmitMargin;
    logic modifiedCompliance;
    logic complianceSkipOrderedSets;
    logic complianceDeemp;
    logic barEnable;
    logic bar64;
    logic barPrefetch;
  } linkCtl_t;
endpackage
`default_nettype wire

// >>> design/cap2_regs.svh
// constants for the second-generation capability register bank
// assumes a dword-addressed configuration access port
//
// Notes on behaviour
// - the ARI forwarding supported bit 5 at 8Ch reads 1 on downstream ports and 0 on the upstream port.
// - the ARI forwarding enable bit 5 at 90h is writable, resets to 0 and acts only on downstream ports.
// - the target link speed at 98h bits 3:0 is writable, 1h means 2.5 Gb/s, 2h means 5.0 Gb/s, and resets to 2h.
// - writing 1 to bit 4 at 98h sends the link into compliance mode, and the bit resets to 0.
// - bit 6 at 98h picks downstream de-emphasis, 0 for -6.0 dB and 1 for -3.5 dB, default 1 down and 0 up.
// - read-only bit 16 at 98h shows the de-emphasis in use on downstream ports and the inverse of bit 6 on the upstream port, 0 for -3.5 dB and 1 for -6.0 dB.
// - bits 10, 11 and 12 at 98h are writable, reset to 0 and act only on the upstream port.
// - the subsystem identification capability header reads 0Dh in bits 7:0.
// - the next-item pointer in bits 15:8 of that header reads 00h unless preset externally.
// - the subsystem vendor code sits read-only in bits 15:0 at A8h and may be preset externally.
// - the subsystem device code sits read-only in bits 31:16 at A8h and may be preset externally.
// - on the upstream port the BAR0 type at E4h bits 1:0 gives 00b off, 10b 32-bit, 11b 64-bit, default 10b.
// - on the upstream port bit 2 at E4h marks BAR0 prefetchable, default 0.
`ifndef CAP2_REGS_SVH
`define CAP2_REGS_SVH
`define OFF_DEVCAP2 8'h8c
`define OFF_DEVCTL2 8'h90
`define OFF_LNKCAP2 8'h94
`define OFF_LNKCTL2 8'h98
`define OFF_SLTCAP2 8'h9c
`define OFF_SLTCTL2 8'ha0
`define OFF_SSCAP 8'ha4
`define OFF_SSCODE 8'ha8
`define OFF_BARCFG 8'he4
`define BIT_ARI 5
`define POS_SPEED 0
`define POS_COMPL 4
`define POS_HWSPD 5
`define POS_DEEMP 6
`define POS_MARGIN 7
`define POS_MODCOMPL 10
`define POS_SKIPOS 11
`define POS_CDEEMP 12
`define POS_CURDEEMP 16
`define POS_NEXTPTR 8
`define POS_BARPF 2
`define SSCAP_ID 8'h0d
`define RST_NEXTPTR 8'h00
`define RST_SPEED 4'h2
`define RST_BARTYPE 2'h2
// arbitrary neutral subsystem codes until a preset arrives
`define RST_VENDOR 16'h0000
`define RST_DEVICE 16'h0000
`define SPEED_2G5 4'h1
`define SPEED_5G0 4'h2
`define BARTYPE_OFF 2'h0
`define BARTYPE_32 2'h2
`define BARTYPE_64 2'h3
`endif

// >>> design/cap2_wr_merge.sv
// byte-lane write merge for one configuration dword
// assumes byte enables follow dword lanes
`include "cap2_regs.svh"
`default_nettype none
module cap2_wr_merge
(
  // old value, write data and lanes
  input wire logic [31:0] oldVal,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  // merged value
  output logic [31:0] newVal
);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      newVal[i*8 +: 8] = be[i] ? wdata[i*8 +: 8] : oldVal[i*8 +: 8];
    end
  end
endmodule
`default_nettype wire

// >>> sim/cfg_host_model.sv
// host side: issues config reads and writes one at a time
// assumes the bank takes a request on the rising edge of clk
`default_nettype none
module cfg_host_model
  import cap2_pkg::*;
(
  // clock
  input wire logic clk,
  // request side
  output logic reqValid,
  output var cfgReq_t req,
  // answer side
  input wire logic rdValid,
  input wire logic [31:0] rdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reqValid = 1'b0;
    req = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    @(negedge clk);
    reqValid = 1'b1;
    req = '{addr: a, wr: 1'b1, be: b, wdata: d};
    @(negedge clk);
    reqValid = 1'b0;
    req = ~req;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic ok);
    ok = 1'b0;
    d = '0;
    @(negedge clk);
    reqValid = 1'b1;
    req = '{addr: a, wr: 1'b0, be: 4'hf, wdata: 32'h0};
    @(negedge clk);
    reqValid = 1'b0;
    req = ~req;
    for (int i = 0; i < 3; i++)
    begin
      if (!ok && rdValid === 1'b1)
      begin
        ok = 1'b1;
        d = rdData;
      end
      if (!ok)
        @(negedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/switch_port_cap2_config_regs_tb.sv
// self-checking bench for the capability register bank
// assumes the host model drives requests at the falling edge
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t mismatch %h vs %h", $time, g, e); end end
module switch_port_cap2_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cap2_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic isDownstream = 1'b0;
  logic presetLoad = 1'b0;
  preset_t preset = '0;
  logic reqValid, rdValid;
  cfgReq_t req;
  logic [31:0] rdData, ctl90, ctl98, bar;
  linkCtl_t linkCtl;
  logic [7:0] np;
  logic [15:0] vc, dc;
  logic [31:0] seed = 32'h0001373c;
  logic [7:0] offs [9] = '{8'h8c, 8'h90, 8'h94, 8'h98, 8'h9c, 8'ha0,
    8'ha4, 8'ha8, 8'he4};
  int mismatches = 0;
  int nTests = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  cap2_config_regs DUT (.clk(clk), .nrst(nrst), .isDownstream(isDownstream),
    .presetLoad(presetLoad), .preset(preset), .reqValid(reqValid),
    .req(req), .rdValid(rdValid), .rdData(rdData), .linkCtl(linkCtl));
  cfg_host_model host (.clk(clk), .reqValid(reqValid), .req(req),
    .rdValid(rdValid), .rdData(rdData));
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++)
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, d,
    input logic [3:0] b);
    for (int i = 0; i < 4; i++)
      if (b[i])
        o[8*i +: 8] = d[8*i +: 8];
    return o;
  endfunction
  function automatic logic [31:0] expRd(input logic [7:0] a);
    case (a)
      8'h8c: return {26'h0, isDownstream, 5'h0};
      8'h90: return {26'h0, ctl90[5], 5'h0};
      8'h98: return {15'h0, ~ctl98[6], 3'h0, ctl98[12:0]};
      8'ha4: return {16'h0, np, 8'h0d};
      8'ha8: return {dc, vc};
      8'he4: return isDownstream ? 32'h0 : {29'h0, bar[2:0]};
      default: return 32'h0;
    endcase
  endfunction
  function automatic linkCtl_t expLink();
    logic up;
    up = ~isDownstream;
    return '{isDownstream & ctl90[5], ctl98[3:0], ctl98[4], ctl98[5],
      isDownstream & ~ctl98[6], ctl98[9:7], up & ctl98[10], up & ctl98[11],
      up & ctl98[12], up & (bar[1:0] != 2'h0), up & (bar[1:0] == 2'h3),
      up & bar[2]};
  endfunction
  task automatic chkRd(input logic [7:0] a);
    logic [31:0] d;
    logic ok;
    host.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, expRd(a))
    `CHK(linkCtl, expLink())
  endtask
  task automatic doWr(input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    host.wr(a, b, d);
    if (a == 8'h90)
      ctl90 = merge(ctl90, d, b);
    if (a == 8'h98)
      ctl98 = merge(ctl98, d, b);
    if (a == 8'he4 && !isDownstream)
      bar = merge(bar, d, b);
    chkRd(a);
  endtask
  task automatic run(input logic dn);
    logic [31:0] d;
    nrst = 1'b0;
    isDownstream = dn;
    repeat (16) @(negedge clk);
    {ctl90, ctl98, bar} = {32'h0, 25'h0, dn, 6'h2, 32'h2};
    {np, vc, dc} = '0;
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    foreach (offs[i])
      chkRd(offs[i]);
    // corner writes: speeds, compliance, de-emphasis, bar types
    doWr(8'h98, 4'h1, 32'h01);
    doWr(8'h98, 4'h1, 32'h12);
    doWr(8'h98, 4'h3, 32'hffbf);
    doWr(8'h90, 4'hf, 32'hffffffff);
    doWr(8'he4, 4'h1, 32'h0);
    doWr(8'he4, 4'h1, 32'h7);
    doWr(8'he4, 4'hf, 32'hfffffff6);
    doWr(8'h8c, 4'hf, 32'hffffffff);
    @(negedge clk);
    presetLoad = 1'b1;
    d = rnd();
    preset = {d[7:0], rnd()};
    @(negedge clk);
    presetLoad = 1'b0;
    {np, vc, dc} = preset;
    chkRd(8'ha4);
    chkRd(8'ha8);
    repeat (40)
    begin
      d = rnd();
      if (d[1:0] == 2'h1)
        d[1] = 1'b1;
      doWr(offs[rnd() % 9], 4'(rnd()), d);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    run(1'b0);
    run(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
